/* src/analog_input_scaling.sv */
// Offset, gain, type select, loss handling and level start for the analog reference.
//
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module analog_input_scaling
  import analog_input_scaling_pkg::*;
#(
  parameter int HOLD_TICKS = HOLD_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] sample_i,
  input wire logic sample_valid_i,
  input wire logic terminal_strip_source_i,
  output logic [15:0] speed_ref_o,
  output logic speed_ref_valid_o,
  output logic signal_lost_o,
  output logic alarm_o,
  output logic fault_o,
  output logic run_request_o
);

  // ----------------------------------------------------------------------------
  // Elaboration checks.
  // ----------------------------------------------------------------------------
  if (HOLD_TICKS < 2) begin : g_bad_params
    $error("analog_input_scaling needs HOLD_TICKS of at least two");
  end

  // ----------------------------------------------------------------------------
  // Helper functions.
  // ----------------------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // True for every 4-20 mA code, the only ones with a live zero and loss detection.
  function automatic logic is_loop_code(input logic [3:0] code);
    return (code == CODE_LOOP_FAULT) || (code == CODE_LOOP_FAULT_NEG) ||
           (code == CODE_LOOP_HOLD) || (code == CODE_LOOP_HOLD_NEG) ||
           (code == CODE_LOOP_PRESET) || (code == CODE_LOOP_PRESET_NEG);
  endfunction

  // Multiply-and-shift avoids a real divider; the ratio 1049 / 2**20 runs about 0.04 percent high.
  function automatic logic signed [47:0] div_by_1000(input logic signed [47:0] p);
    logic signed [47:0] m;
    m = p * $signed({32'h0000_0000, DIV1000_MUL});
    return m >>> DIV1000_SHIFT;
  endfunction

  function automatic logic [15:0] sat16(input logic signed [47:0] v);
    if (v > 48'sh0000_0000_7FFF) begin
      return 16'h7FFF;
    end else if (v < -48'sh0000_0000_8000) begin
      return 16'h8000;
    end else begin
      return v[15:0];
    end
  endfunction

  // ----------------------------------------------------------------------------
  // Registers and state.
  // ----------------------------------------------------------------------------
  logic [15:0] offset_reg;
  logic [15:0] gain_reg;
  logic [3:0] type_reg;
  logic [15:0] preset_reg;
  logic [15:0] start_thr_reg;
  logic [15:0] stop_thr_reg;
  logic fault_reg;
  logic reject_reg;
  logic ack_reg;
  logic [15:0] ref_reg;
  logic ref_valid_reg;
  logic [15:0] held_reg;
  loss_state_t loss_reg;
  loss_state_t loss_next;
  run_state_t run_reg;
  logic access;
  logic wr_en;
  logic [31:0] offset_wr;
  logic [31:0] gain_wr;
  logic [31:0] type_wr;
  logic reject_set;
  logic loss_enter;
  logic [15:0] hist_held;
  logic [15:0] conv_value;
  logic [15:0] ref_next;
  logic signed [17:0] sum;
  logic signed [47:0] prod;
  logic signed [47:0] scaled;

  // ----------------------------------------------------------------------------
  // Wishbone slave: one wait state, then ack for exactly one cycle.
  // ----------------------------------------------------------------------------
  assign access = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_en = access && wb_we_i;
  assign wb_ack_o = ack_reg;
  assign offset_wr = merge_bytes({{16{offset_reg[15]}}, offset_reg}, wb_dat_i, wb_sel_i);
  assign gain_wr = merge_bytes({16'h0000, gain_reg}, wb_dat_i, wb_sel_i);
  assign type_wr = merge_bytes({28'h000_0000, type_reg}, wb_dat_i, wb_sel_i);

  // Ack drops the cycle after it rises, even if the master keeps the strobe high.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= access;
    end
  end

  // Read data is latched with ack; unmapped offsets read as zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (access && !wb_we_i) begin
      if (wb_adr_i == REG_OFFSET_ADDR) begin
        wb_dat_o <= {{16{offset_reg[15]}}, offset_reg};
      end else if (wb_adr_i == REG_GAIN_ADDR) begin
        wb_dat_o <= {16'h0000, gain_reg};
      end else if (wb_adr_i == REG_TYPE_ADDR) begin
        wb_dat_o <= {28'h000_0000, type_reg};
      end else if (wb_adr_i == REG_PRESET_ADDR) begin
        wb_dat_o <= {{16{preset_reg[15]}}, preset_reg};
      end else if (wb_adr_i == REG_START_ADDR) begin
        wb_dat_o <= {{16{start_thr_reg[15]}}, start_thr_reg};
      end else if (wb_adr_i == REG_STOP_ADDR) begin
        wb_dat_o <= {{16{stop_thr_reg[15]}}, stop_thr_reg};
      end else if (wb_adr_i == REG_STATUS_ADDR) begin
        wb_dat_o <= {27'h000_0000, run_reg == RUN_RUNNING, reject_reg, fault_reg,
                     alarm_o, signal_lost_o};
      end else if (wb_adr_i == REG_REF_ADDR) begin
        wb_dat_o <= {{16{ref_reg[15]}}, ref_reg};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Setting registers with range checks.
  // ----------------------------------------------------------------------------
  // A write outside the range leaves the setting untouched and flags the rejection.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      offset_reg <= OFFSET_RESET;
      gain_reg <= GAIN_RESET;
      type_reg <= TYPE_RESET;
    end else if (wr_en) begin
      if (wb_adr_i == REG_OFFSET_ADDR && $signed(offset_wr) >= OFFSET_MIN &&
          $signed(offset_wr) <= OFFSET_MAX) begin
        offset_reg <= offset_wr[15:0];
      end else if (wb_adr_i == REG_GAIN_ADDR && gain_wr >= GAIN_MIN && gain_wr <= GAIN_MAX) begin
        gain_reg <= gain_wr[15:0];
      end else if (wb_adr_i == REG_TYPE_ADDR && type_wr <= TYPE_MAX) begin
        type_reg <= type_wr[3:0];
      end
    end
  end

  assign reject_set = wr_en && (
      (wb_adr_i == REG_OFFSET_ADDR &&
       ($signed(offset_wr) < OFFSET_MIN || $signed(offset_wr) > OFFSET_MAX)) ||
      (wb_adr_i == REG_GAIN_ADDR && (gain_wr < GAIN_MIN || gain_wr > GAIN_MAX)) ||
      (wb_adr_i == REG_TYPE_ADDR && type_wr > TYPE_MAX));

  // Unchecked settings: preset substitute speed and the level start and stop thresholds.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      preset_reg <= PRESET_RESET;
      start_thr_reg <= START_RESET;
      stop_thr_reg <= STOP_RESET;
    end else if (wr_en) begin
      if (wb_adr_i == REG_PRESET_ADDR) begin
        preset_reg <= 16'(merge_bytes({16'h0000, preset_reg}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == REG_START_ADDR) begin
        start_thr_reg <= 16'(merge_bytes({16'h0000, start_thr_reg}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == REG_STOP_ADDR) begin
        stop_thr_reg <= 16'(merge_bytes({16'h0000, stop_thr_reg}, wb_dat_i, wb_sel_i));
      end
    end
  end

  // Sticky flags clear on a written one; a set condition in the same cycle wins, so fault stays set while a fault-code loss lasts.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_reg <= 1'b0;
      reject_reg <= 1'b0;
    end else begin
      if (loss_next == LOSS_LOST && (type_reg == CODE_LOOP_FAULT ||
          type_reg == CODE_LOOP_FAULT_NEG)) begin
        fault_reg <= 1'b1;
      end else if (wr_en && wb_adr_i == REG_STATUS_ADDR && wb_sel_i[0] &&
                   wb_dat_i[ST_FAULT_BIT]) begin
        fault_reg <= 1'b0;
      end
      if (reject_set) begin
        reject_reg <= 1'b1;
      end else if (wr_en && wb_adr_i == REG_STATUS_ADDR && wb_sel_i[0] &&
                   wb_dat_i[ST_REJECT_BIT]) begin
        reject_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Conversion datapath. One count is 10 mV or 20 uA, the same as one offset step.
  // ----------------------------------------------------------------------------
  always_comb begin
    sum = 18'(signed'(sample_i)) + 18'(signed'(offset_reg));
    if (is_loop_code(type_reg)) begin
      sum = sum - 18'(FOUR_MA_COUNTS);
    end
    if (type_reg != CODE_BIPOLAR && type_reg != CODE_BIPOLAR_NEG && sum < 0) begin
      sum = '0;
    end
    prod = 48'(sum) * $signed({32'h0000_0000, gain_reg});
    scaled = div_by_1000(prod);
    if (type_reg[0]) begin
      scaled = -scaled;
    end
    conv_value = sat16(scaled);
  end

  // ----------------------------------------------------------------------------
  // Loss detection with 2 mA entry and 4 mA return hysteresis.
  // ----------------------------------------------------------------------------
  always_comb begin
    loss_next = loss_reg;
    case (loss_reg)
      LOSS_OK: begin
        if (sample_valid_i && is_loop_code(type_reg) && signed'(sample_i) < TWO_MA_COUNTS) begin
          loss_next = LOSS_LOST;
        end
      end
      LOSS_LOST: begin
        if (!is_loop_code(type_reg)) begin
          loss_next = LOSS_OK;
        end else if (sample_valid_i && signed'(sample_i) >= FOUR_MA_COUNTS) begin
          loss_next = LOSS_OK;
        end
      end
      default: loss_next = LOSS_OK;
    endcase
  end

  assign loss_enter = (loss_reg == LOSS_OK) && (loss_next == LOSS_LOST);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loss_reg <= LOSS_OK;
    end else begin
      loss_reg <= loss_next;
    end
  end

  // The history only sees good references, so it freezes while the signal is lost.
  reference_history #(
    .WIDTH(16),
    .SLOTS(HOLD_SLOTS),
    .TICK_CYCLES(HOLD_TICKS)
  ) u_history (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(loss_reg == LOSS_OK),
    .value_i(ref_reg),
    .held_o(hist_held)
  );

  // Capture the 4 to 5 s old value at the moment the loss is seen.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      held_reg <= 16'h0000;
    end else if (loss_enter) begin
      held_reg <= hist_held;
    end
  end

  // ----------------------------------------------------------------------------
  // Reference selection and output.
  // ----------------------------------------------------------------------------
  always_comb begin
    ref_next = conv_value;
    if (loss_next == LOSS_LOST) begin
      case (type_reg)
        CODE_LOOP_HOLD, CODE_LOOP_HOLD_NEG: ref_next = loss_enter ? hist_held : held_reg;
        CODE_LOOP_PRESET, CODE_LOOP_PRESET_NEG: ref_next = preset_reg;
        default: ref_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_reg <= 16'h0000;
      ref_valid_reg <= 1'b0;
    end else begin
      ref_valid_reg <= sample_valid_i;
      if (sample_valid_i) begin
        ref_reg <= ref_next;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Level start and stop for code 12; the control source must be the terminal strip.
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_reg <= RUN_STOPPED;
    end else begin
      case (run_reg)
        RUN_STOPPED: begin
          if (type_reg == CODE_VOLT_RUN && terminal_strip_source_i &&
              signed'(ref_reg) >= signed'(start_thr_reg)) begin
            run_reg <= RUN_RUNNING;
          end
        end
        RUN_RUNNING: begin
          if (type_reg != CODE_VOLT_RUN || !terminal_strip_source_i ||
              signed'(ref_reg) < signed'(stop_thr_reg)) begin
            run_reg <= RUN_STOPPED;
          end
        end
        default: run_reg <= RUN_STOPPED;
      endcase
    end
  end

  assign speed_ref_o = ref_reg;
  assign speed_ref_valid_o = ref_valid_reg;
  // A non-loop code never reports loss, even in the cycle before the state leaves it.
  assign signal_lost_o = (loss_reg == LOSS_LOST) && is_loop_code(type_reg);
  assign alarm_o = (loss_reg == LOSS_LOST) && (type_reg == CODE_LOOP_HOLD ||
                   type_reg == CODE_LOOP_HOLD_NEG || type_reg == CODE_LOOP_PRESET ||
                   type_reg == CODE_LOOP_PRESET_NEG);
  assign fault_o = fault_reg;
  assign run_request_o = (run_reg == RUN_RUNNING);

endmodule
`default_nettype wire

/* src/analog_input_scaling_pkg.sv */
// Constants, register map and types for the analog reference input scaling block.
package analog_input_scaling_pkg;

  // ----------------------------------------------------------------------------
  // Clock and timing.
  // ----------------------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 32'h0131_2D00; // 20 MHz system clock.
  localparam int MS_PER_S = 32'h0000_03E8; // 1000 ms in one second.
  localparam int HOLD_TICK_MS = 32'h0000_03E8; // History sampling period, 1000 ms.
  localparam int HOLD_TICK_CYCLES = CLK_FREQ_HZ / MS_PER_S * HOLD_TICK_MS;
  localparam int HOLD_SLOTS = 32'h0000_0005; // Five one-second slots give a 4 to 5 s old value.

  // ----------------------------------------------------------------------------
  // Register byte offsets on the Wishbone slave.
  // ----------------------------------------------------------------------------
  localparam logic [7:0] REG_OFFSET_ADDR = 8'h00;
  localparam logic [7:0] REG_GAIN_ADDR = 8'h04;
  localparam logic [7:0] REG_TYPE_ADDR = 8'h08;
  localparam logic [7:0] REG_PRESET_ADDR = 8'h0C;
  localparam logic [7:0] REG_START_ADDR = 8'h10;
  localparam logic [7:0] REG_STOP_ADDR = 8'h14;
  localparam logic [7:0] REG_STATUS_ADDR = 8'h18;
  localparam logic [7:0] REG_REF_ADDR = 8'h1C;

  // ----------------------------------------------------------------------------
  // Setting limits and reset values. One count is 10 mV or 20 uA.
  // ----------------------------------------------------------------------------
  localparam logic signed [31:0] OFFSET_MIN = 32'shFFFF_FC7C; // -900 counts.
  localparam logic signed [31:0] OFFSET_MAX = 32'sh0000_0384; // +900 counts.
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam logic [31:0] GAIN_MIN = 32'h0000_0064; // 0.100 in thousandths.
  localparam logic [31:0] GAIN_MAX = 32'h0000_1388; // 5.000 in thousandths.
  localparam logic [15:0] GAIN_RESET = 16'h03E8; // 1.000 in thousandths.
  localparam logic [31:0] TYPE_MAX = 32'h0000_000C; // Highest input type code, 12.
  localparam logic [3:0] TYPE_RESET = 4'h2;
  localparam logic [15:0] PRESET_RESET = 16'h0000;
  localparam logic [15:0] START_RESET = 16'h0032; // Run at 50 counts or more.
  localparam logic [15:0] STOP_RESET = 16'h0014; // Stop below 20 counts.

  // ----------------------------------------------------------------------------
  // Loop current levels and fixed-point helpers.
  // ----------------------------------------------------------------------------
  localparam logic signed [15:0] TWO_MA_COUNTS = 16'sh0064; // 2 mA, loss threshold.
  localparam logic signed [15:0] FOUR_MA_COUNTS = 16'sh00C8; // 4 mA, live zero and return.
  localparam logic [15:0] DIV1000_MUL = 16'h0419; // 1049 / 2**20 is close to 1/1000.
  localparam int DIV1000_SHIFT = 32'h0000_0014; // Shift of 20.

  // ----------------------------------------------------------------------------
  // Status register bit positions.
  // ----------------------------------------------------------------------------
  localparam int ST_LOST_BIT = 0;
  localparam int ST_ALARM_BIT = 1;
  localparam int ST_FAULT_BIT = 2;
  localparam int ST_REJECT_BIT = 3;
  localparam int ST_RUN_BIT = 4;

  // ----------------------------------------------------------------------------
  // Input type codes and state machine types.
  // ----------------------------------------------------------------------------
  typedef enum logic [3:0] {
    CODE_BIPOLAR = 4'h0,
    CODE_BIPOLAR_NEG = 4'h1,
    CODE_VOLT = 4'h2,
    CODE_VOLT_NEG = 4'h3,
    CODE_LOOP_FAULT = 4'h4,
    CODE_LOOP_FAULT_NEG = 4'h5,
    CODE_CURRENT = 4'h6,
    CODE_CURRENT_NEG = 4'h7,
    CODE_LOOP_HOLD = 4'h8,
    CODE_LOOP_HOLD_NEG = 4'h9,
    CODE_LOOP_PRESET = 4'hA,
    CODE_LOOP_PRESET_NEG = 4'hB,
    CODE_VOLT_RUN = 4'hC
  } input_code_t;

  typedef enum logic [0:0] {
    LOSS_OK = 1'b0,
    LOSS_LOST = 1'b1
  } loss_state_t;

  typedef enum logic [0:0] {
    RUN_STOPPED = 1'b0,
    RUN_RUNNING = 1'b1
  } run_state_t;

endpackage

/* src/reference_history.sv */
// Ring of once-per-tick reference samples that yields the value 4 to 5 ticks old.
`timescale 1ns/100ps
`default_nettype none
module reference_history #(
  parameter int WIDTH = 16,
  parameter int SLOTS = 5,
  parameter int TICK_CYCLES = 20000000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic [WIDTH-1:0] value_i,
  output logic [WIDTH-1:0] held_o
);

  localparam int CW = $clog2(TICK_CYCLES);
  localparam int PW = (SLOTS > 1) ? $clog2(SLOTS) : 1;

  // ----------------------------------------------------------------------------
  // Elaboration checks.
  // ----------------------------------------------------------------------------
  if (SLOTS < 2 || TICK_CYCLES < 2 || WIDTH < 1) begin : g_bad_params
    $error("reference_history needs at least two slots, two cycles a tick and one bit");
  end

  logic [CW-1:0] tick_cnt_reg;
  logic [PW-1:0] wr_ptr_reg;
  logic [WIDTH-1:0] slot_mem [SLOTS];
  logic tick;

  assign tick = (tick_cnt_reg == CW'(TICK_CYCLES - 1));

  // Free-running tick divider; it keeps counting while frozen so the phase stays regular.
  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + CW'(1);
    end
  end

  // Writes stop while frozen so a failing signal never pollutes the history.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      for (int i = 0; i < SLOTS; i++) begin
        slot_mem[i] <= '0;
      end
    end else if (tick && enable_i) begin
      slot_mem[wr_ptr_reg] <= value_i;
      wr_ptr_reg <= (wr_ptr_reg == PW'(SLOTS - 1)) ? '0 : wr_ptr_reg + PW'(1);
    end
  end

  // The slot about to be overwritten is the oldest one.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      held_o <= '0;
    end else begin
      held_o <= slot_mem[wr_ptr_reg];
    end
  end

endmodule
`default_nettype wire

/* verification/analog_input_scaling_sva.sv */
// Assertion checker for the analog reference scaling block, bound to its top module.
`timescale 1ns/100ps
`default_nettype none
module analog_input_scaling_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [15:0] sample_i,
  input wire logic sample_valid_i,
  input wire logic terminal_strip_source_i,
  input wire logic [15:0] speed_ref_o,
  input wire logic speed_ref_valid_o,
  input wire logic signal_lost_o,
  input wire logic alarm_o,
  input wire logic fault_o,
  input wire logic run_request_o
);
  // ----------------------------------------------------------------------------
  // Single clock domain, so one default clocking and disable.
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Bus answers a taken request exactly one cycle later, as a single pulse.
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  // Every sample yields one new reference a cycle later and none without it.
  AST_REF_VALID: assert property (sample_valid_i |=> speed_ref_valid_o)
    else $error("no reference after sample");
  AST_NO_SPURIOUS: assert property (!sample_valid_i |=> !speed_ref_valid_o)
    else $error("reference without sample");
  AST_REF_STABLE: assert property (!speed_ref_valid_o |-> $stable(speed_ref_o))
    else $error("reference moved between samples");
  // Loss handling: alarm only with loss; fault codes force zero and fault.
  AST_ALARM_LOST: assert property (alarm_o |-> signal_lost_o)
    else $error("alarm without loss");
  AST_ZERO_REF: assert property (speed_ref_valid_o && signal_lost_o && !alarm_o
    |-> speed_ref_o == 16'h0000)
    else $error("fault loss reference not zero");
  AST_FAULT_LOSS: assert property (signal_lost_o && !alarm_o |-> fault_o)
    else $error("fault not raised on loss");
  AST_LOSS_EXIT: assert property (sample_valid_i && $signed(sample_i) >= 200
    |=> !signal_lost_o)
    else $error("loss kept at 4 mA or more");
  // Hazard: a run request without the terminal strip would start the drive remotely.
  AST_RUN_SOURCE: assert property (!terminal_strip_source_i [*3] |-> !run_request_o)
    else $error("run without terminal strip source");
endmodule
bind analog_input_scaling analog_input_scaling_sva analog_input_scaling_sva_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .sample_i(sample_i), .sample_valid_i(sample_valid_i),
  .terminal_strip_source_i(terminal_strip_source_i), .speed_ref_o(speed_ref_o),
  .speed_ref_valid_o(speed_ref_valid_o), .signal_lost_o(signal_lost_o),
  .alarm_o(alarm_o), .fault_o(fault_o), .run_request_o(run_request_o));
`default_nettype wire

/* verification/reference_source.sv */
// Behavioural converter model that delivers one sample every few cycles.
`timescale 1ns/100ps
`default_nettype none
module reference_source (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] level_i,
  output logic [15:0] sample_o,
  output logic sample_valid_o
);
  logic [1:0] cnt_reg;
  // Between samples the data lines toggle, so nothing relies on stale data.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 2'h0;
      sample_o <= 16'h0000;
      sample_valid_o <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
      sample_valid_o <= (cnt_reg == 2'h0);
      sample_o <= (cnt_reg == 2'h0) ? level_i : ~sample_o;
    end
  end
endmodule
`default_nettype wire

/* verification/analog_input_scaling_tb_top.sv */
// Self-checking testbench for the analog reference scaling block.
`timescale 1ns/100ps
`default_nettype none
module analog_input_scaling_tb_top;
  import analog_input_scaling_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, src = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, q, rdat;
  logic [15:0] level = 16'h0000, smp, ref_o, r;
  logic svld, rvld, ack, lost, alm, flt, run, l, a, f;
  int err_count = 0, comparisons = 0, cd[7] = '{0, 1, 2, 3, 6, 7, 12};
  event hang;
  analog_input_scaling #(.HOLD_TICKS(20)) analog_input_scaling_inst (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sample_i(smp),
    .sample_valid_i(svld), .terminal_strip_source_i(src), .speed_ref_o(ref_o),
    .speed_ref_valid_o(rvld), .signal_lost_o(lost), .alarm_o(alm), .fault_o(flt),
    .run_request_o(run));
  reference_source reference_source_inst (.clk_i(clk_i), .rst_i(rst_i), .level_i(level),
    .sample_o(smp), .sample_valid_o(svld));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // ----------------------------------------------------------------------------
  // Bus cycle, sample capture and comparison helpers.
  // ----------------------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= ad; wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (ack !== 1'b1) -> hang;
    q = rdat;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  // Values seen at the edge are the ones present before it, so no race.
  task automatic take(input logic [15:0] lv);
    int k, n;
    k = 0; n = 0;
    level <= lv;
    while (k < 2 && n < 40) begin
      @(posedge clk_i);
      n++;
      if (rvld === 1'b1) k++;
    end
    if (k < 2) -> hang;
    r = ref_o; l = lost; a = alm; f = flt;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Reference model of the scaling arithmetic, floor division included.
  function automatic logic [15:0] ex(input int s, input int off, input int g, input int c);
    longint v;
    v = s + off - ((c inside {4, 5, 8, 9, 10, 11}) ? 200 : 0);
    if (c > 1 && v < 0) v = 0;
    v = (v * g * 1049) >>> 20;
    if (c % 2 == 1) v = -v;
    return v[15:0];
  endfunction
  task automatic tally_and_finish;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    @(hang);
    err_count++;
    tally_and_finish();
  end
  // ----------------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 8'h00, 0); chk(q[15:0], 16'h0000);
    wb(0, 8'h04, 0); chk(q[15:0], 16'h03E8);
    wb(0, 8'h08, 0); chk(q[15:0], 16'h0002);
    wb(1, 8'h00, 32'hFFFF_FC7C); wb(1, 8'h00, 32'h0000_0385);
    wb(0, 8'h00, 0); chk(q[15:0], 16'hFC7C);
    wb(1, 8'h04, 32'h0000_0063); wb(0, 8'h04, 0); chk(q[15:0], 16'h03E8);
    wb(1, 8'h08, 32'h0000_000D); wb(0, 8'h08, 0); chk(q[15:0], 16'h0002);
    wb(0, 8'h18, 0); chk(q[15:0] & 16'h0008, 16'h0008);
    wb(0, 8'h24, 0); chk(q[15:0], 16'h0000);
    wb(1, 8'h00, 32'h0000_0032); wb(1, 8'h04, 32'h0000_07D0);
    for (int i = 0; i < 7; i++) begin
      wb(1, 8'h08, cd[i]);
      take(16'h0190); chk(r, ex(400, 50, 2000, cd[i]));
      take(16'hFED4); chk(r, ex(-300, 50, 2000, cd[i]));
    end
    wb(1, 8'h00, 0); wb(1, 8'h04, 32'h0000_03E8); wb(1, 8'h08, 32'h0000_0004);
    take(16'h012C); chk(r, ex(300, 0, 1000, 4));
    take(16'h0032); chk({r[13:0], l, f}, 16'h0003);
    take(16'h0096); chk({a, l, r[13:0]}, 16'h4000);
    take(16'h00FA); chk(r, ex(250, 0, 1000, 4));
    wb(1, 8'h18, 32'h0000_0004); wb(0, 8'h18, 0); chk(q[15:0] & 16'h0005, 16'h0000);
    wb(1, 8'h0C, 32'h0000_004D); wb(1, 8'h08, 32'h0000_000A);
    take(16'h0032); chk({a, l, r[13:0]}, 16'hC04D);
    take(16'h012C); chk({a, l, r[13:0]}, ex(300, 0, 1000, 10));
    wb(1, 8'h08, 32'h0000_0009);
    take(16'h012C);
    repeat (200) @(posedge clk_i);
    take(16'h00C8);
    take(16'h0032); chk(r, ex(300, 0, 1000, 9)); chk({a, f}, 2'b10);
    wb(1, 8'h08, 32'h0000_000C);
    src <= 1;
    take(16'h0064); repeat (2) @(posedge clk_i); chk(run, 1'b1);
    take(16'h000A); repeat (2) @(posedge clk_i); chk(run, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
